// ---- core/pbwb_pkg.sv ----
package pbwb_pkg;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned WAIT_W  = 5;
  localparam int unsigned RATIO_W = 4;
  localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;
  localparam logic [WAIT_W-1:0]  WAIT_RST  = 5'h00;
  localparam logic [RATIO_W-1:0] PHASE_RST = 4'h0;

  // ************************************************************
  // Wait figures in processor clocks
  // ************************************************************
  localparam logic [WAIT_W-1:0] WAIT_SERIAL   = 5'h01;
  localparam logic [WAIT_W-1:0] WAIT_NONE     = 5'h00;
  localparam logic [WAIT_W-1:0] WAIT_MIN_FAST = 5'h01;
  localparam logic [WAIT_W-1:0] WAIT_MIN_SLOW = 5'h02;
  localparam logic [RATIO_W-1:0] FAST_RATIO_MAX = 4'h4;

  // ************************************************************
  // Converter clock selection and register targets
  // ************************************************************
  typedef enum logic [2:0] {
    PBWB_DIV2  = 3'h0,
    PBWB_DIV3  = 3'h1,
    PBWB_DIV4  = 3'h2,
    PBWB_DIV6  = 3'h3,
    PBWB_DIV8  = 3'h4,
    PBWB_DIV12 = 3'h5
  } pbwb_div_type;

  typedef enum logic [2:0] {
    PBWB_OTHER                    = 3'h0,
    PBWB_SERIAL_A_RECEIVE_STATUS  = 3'h1,
    PBWB_SERIAL_B_RECEIVE_STATUS  = 3'h2,
    PBWB_CONVERTER_MODE_REG       = 3'h3,
    PBWB_CONVERTER_CHANNEL_SELECT = 3'h4,
    PBWB_CONVERTER_PORT_CONFIG    = 3'h5,
    PBWB_CONVERTER_RESULT_REG     = 3'h6
  } pbwb_target_type;

  typedef struct packed {
    logic                valid;
    logic                write;
    pbwb_target_type     target;
    logic [DATA_W-1:0]   wdata;
  } pbwb_req_type;

  typedef struct packed {
    logic                strobe;
    logic                write;
    pbwb_target_type     target;
    logic [DATA_W-1:0]   wdata;
  } pbwb_periph_type;

endpackage

// ---- core/pbwb_divider.sv ----
`timescale 1ns/1ps

// Converter clock enable from the processor clock, plus its phase
module pbwb_divider #(
  parameter int unsigned RATIO_W = 4
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // Control
  input  wire logic               run,
  input  wire logic [RATIO_W-1:0] ratio,
  // Enable and phase
  output logic                    tick_q,
  output logic [RATIO_W-1:0]      phase_q
);
  import pbwb_pkg::*;

  logic               tick_d;
  logic [RATIO_W-1:0] phase_d;

  // Phase advances per processor clock, frozen while stopped
  always_comb begin
    phase_d = phase_q;
    tick_d  = 1'b0;
    if (run) begin
      if (phase_q >= ratio - 1'b1) begin
        phase_d = '0;
        tick_d  = 1'b1;
      end else begin
        phase_d = phase_q + 1'b1;
      end
    end
  end

  // Divider state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      tick_q  <= tick_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_frozen_when_stopped;
    @(posedge core_clk) disable iff (!rst_n)
      !run |=> !tick_q && $stable(phase_q);
  endproperty
  a_frozen_when_stopped: assert property (p_frozen_when_stopped)
    else $error("converter phase moved while peripheral clock stopped");

endmodule

// ---- core/pbwb_bridge.sv ----
`timescale 1ns/1ps

// Summary of operation
// - Separate processor and peripheral buses; bridge guards colliding accesses.
// - Colliding accesses are held for the counted wait clocks, then transferred once.
// - Each wait clock stretches the current access by one processor cycle.
// - Serial status reads wait one clock; converter setup writes and result reads wait variably.
// - Converter waits 1-5, 1-7, 1-9 at divide by 2, 3, 4.
// - Converter waits 2-13, 2-17, 2-25 at divide by 6, 8, 12.
// - Maximum converter wait is twice processor over converter clock, plus one.
// - Wait figures assume processor and peripheral clocks share one source.
// - Wait clocks are counted in processor clock cycles.
module pbwb_bridge #(
  parameter int unsigned DATA_W = 8
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Processor side
  input  wire pbwb_pkg::pbwb_req_type    cpu_req,
  output logic                           cpu_wait_q,
  output logic                           cpu_done_q,
  output logic [DATA_W-1:0]              cpu_rdata_q,
  // Converter clock setup
  input  wire pbwb_pkg::pbwb_div_type    div_sel,
  input  wire logic                      periph_clk_run,
  // Peripheral side
  output pbwb_pkg::pbwb_periph_type      periph_q,
  input  wire logic [DATA_W-1:0]         periph_rdata
);
  import pbwb_pkg::*;

  if (DATA_W != pbwb_pkg::DATA_W) begin : g_bad_width
    $error("DATA_W must match the package");
  end

  // ************************************************************
  // Wait decoding
  // ************************************************************
  function automatic logic [RATIO_W-1:0] ratio_of(input pbwb_div_type sel);
    unique case (sel)
      PBWB_DIV2:  ratio_of = 4'h2;
      PBWB_DIV3:  ratio_of = 4'h3;
      PBWB_DIV4:  ratio_of = 4'h4;
      PBWB_DIV6:  ratio_of = 4'h6;
      PBWB_DIV8:  ratio_of = 4'h8;
      PBWB_DIV12: ratio_of = 4'hC;
      default:    ratio_of = 4'h2;
    endcase
  endfunction

  // Twice the clock ratio plus one; integer ratio leaves no fraction
  function automatic logic [WAIT_W-1:0] max_wait(input logic [RATIO_W-1:0] r);
    max_wait = {r, 1'b1};
  endfunction

  function automatic logic [WAIT_W-1:0] min_wait(input logic [RATIO_W-1:0] r);
    min_wait = (r <= FAST_RATIO_MAX) ? WAIT_MIN_FAST : WAIT_MIN_SLOW;
  endfunction

  function automatic logic is_conv(input pbwb_req_type q);
    is_conv = (q.write && (q.target == PBWB_CONVERTER_MODE_REG ||
                           q.target == PBWB_CONVERTER_CHANNEL_SELECT ||
                           q.target == PBWB_CONVERTER_PORT_CONFIG)) ||
              (!q.write && q.target == PBWB_CONVERTER_RESULT_REG);
  endfunction

  function automatic logic is_serial(input pbwb_req_type q);
    is_serial = !q.write && (q.target == PBWB_SERIAL_A_RECEIVE_STATUS ||
                             q.target == PBWB_SERIAL_B_RECEIVE_STATUS);
  endfunction

  // ************************************************************
  // Converter clock divider
  // ************************************************************
  logic [RATIO_W-1:0] ratio;
  logic [RATIO_W-1:0] phase;

  assign ratio = ratio_of(div_sel);

  // Shared source: converter clock is an enable from the processor clock
  pbwb_divider #(.RATIO_W(RATIO_W)) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (periph_clk_run),
    .ratio    (ratio),
    .tick_q   (),
    .phase_q  (phase)
  );

  // Wait needed by a fresh request; late phase lands near the converter edge
  logic [WAIT_W-1:0] need;
  always_comb begin
    if (is_serial(cpu_req)) begin
      need = WAIT_SERIAL;
    end else if (is_conv(cpu_req)) begin
      if (phase == ratio - 1'b1) begin
        need = min_wait(ratio);
      end else begin
        need = max_wait(ratio) - WAIT_W'({phase, 1'b0});
      end
    end else begin
      need = WAIT_NONE;
    end
  end

  // ************************************************************
  // Access sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    PBWB_IDLE = 2'b00,
    PBWB_WAIT = 2'b01,
    PBWB_XFER = 2'b10
  } pbwb_state_type;

  pbwb_state_type    state_q, state_d;
  logic [WAIT_W-1:0] cnt_q, cnt_d;
  logic              wait_d, done_d;
  logic [DATA_W-1:0] rdata_d;
  pbwb_periph_type   periph_d;
  logic              accept;

  assign accept = (state_q == PBWB_IDLE) && cpu_req.valid;

  // Next state; processor is held while the count runs
  always_comb begin
    state_d         = state_q;
    cnt_d           = cnt_q;
    wait_d          = 1'b0;
    done_d          = 1'b0;
    rdata_d         = cpu_rdata_q;
    periph_d        = periph_q;
    periph_d.strobe = 1'b0;
    unique case (state_q)
      PBWB_IDLE: begin
        if (cpu_req.valid) begin
          periph_d.write  = cpu_req.write;
          periph_d.target = cpu_req.target;
          periph_d.wdata  = cpu_req.wdata;
          if (need == WAIT_NONE) begin
            state_d         = PBWB_XFER;
            periph_d.strobe = 1'b1;
          end else begin
            state_d = PBWB_WAIT;
            cnt_d   = need;
            wait_d  = 1'b1;
          end
        end
      end
      PBWB_WAIT: begin
        // One processor cycle per wait clock
        if (cnt_q == 5'h01) begin
          state_d         = PBWB_XFER;
          periph_d.strobe = 1'b1;
          cnt_d           = WAIT_RST;
        end else begin
          cnt_d  = cnt_q - 1'b1;
          wait_d = 1'b1;
        end
      end
      PBWB_XFER: begin
        state_d = PBWB_IDLE;
        done_d  = 1'b1;
        if (!periph_q.write) begin
          rdata_d = periph_rdata;
        end
      end
      default: begin
        state_d = PBWB_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= PBWB_IDLE;
      cnt_q       <= WAIT_RST;
      cpu_wait_q  <= 1'b0;
      cpu_done_q  <= 1'b0;
      cpu_rdata_q <= DATA_RST;
      periph_q    <= '{strobe: 1'b0, write: 1'b0, target: PBWB_OTHER, wdata: DATA_RST};
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      cpu_wait_q  <= wait_d;
      cpu_done_q  <= done_d;
      cpu_rdata_q <= rdata_d;
      periph_q    <= periph_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [WAIT_W-1:0] need_q;
  logic [WAIT_W-1:0] waited_q;
  logic [RATIO_W-1:0] ratio_q;
  logic              conv_q;
  logic              serial_q;

  // Helper: what the current access asked for and how long it waited
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      need_q   <= WAIT_RST;
      waited_q <= WAIT_RST;
      ratio_q  <= PHASE_RST;
      conv_q   <= 1'b0;
      serial_q <= 1'b0;
    end else if (accept) begin
      need_q   <= need;
      waited_q <= WAIT_RST;
      ratio_q  <= ratio;
      conv_q   <= is_conv(cpu_req);
      serial_q <= is_serial(cpu_req);
    end else if (cpu_wait_q) begin
      waited_q <= waited_q + 1'b1;
    end
  end

  property p_strobe_then_done;
    @(posedge core_clk) disable iff (!rst_n)
      periph_q.strobe |=> cpu_done_q && !periph_q.strobe;
  endproperty
  a_strobe_then_done: assert property (p_strobe_then_done)
    else $error("peripheral transfer not followed by done");

  property p_held_no_transfer;
    @(posedge core_clk) disable iff (!rst_n)
      cpu_wait_q |-> !cpu_done_q && !periph_q.strobe;
  endproperty
  a_held_no_transfer: assert property (p_held_no_transfer)
    else $error("transfer while processor held");

  property p_wait_length;
    @(posedge core_clk) disable iff (!rst_n)
      cpu_done_q |-> waited_q == need_q;
  endproperty
  a_wait_length: assert property (p_wait_length)
    else $error("wait clocks differ from requested count");

  property p_serial_one;
    @(posedge core_clk) disable iff (!rst_n)
      accept && is_serial(cpu_req) |=> cpu_wait_q ##1 (!cpu_wait_q && periph_q.strobe);
  endproperty
  a_serial_one: assert property (p_serial_one)
    else $error("serial status read not exactly one wait");

  property p_fast_range;
    @(posedge core_clk) disable iff (!rst_n)
      cpu_done_q && conv_q && ratio_q <= 4'h4 |->
        waited_q >= 5'h01 && waited_q <= {ratio_q, 1'b1};
  endproperty
  a_fast_range: assert property (p_fast_range)
    else $error("fast converter wait out of range");

  property p_slow_range;
    @(posedge core_clk) disable iff (!rst_n)
      cpu_done_q && conv_q && ratio_q > 4'h4 |->
        waited_q >= 5'h02 && waited_q <= {ratio_q, 1'b1};
  endproperty
  a_slow_range: assert property (p_slow_range)
    else $error("slow converter wait out of range");

  property p_max_at_phase0;
    @(posedge core_clk) disable iff (!rst_n)
      accept && is_conv(cpu_req) && phase == 4'h0 |=> cnt_q == {ratio_q, 1'b1};
  endproperty
  a_max_at_phase0: assert property (p_max_at_phase0)
    else $error("maximum converter wait not reached");

  property p_count_down;
    @(posedge core_clk) disable iff (!rst_n)
      state_q == PBWB_WAIT && cnt_q > 5'h01 |=> cnt_q == $past(cnt_q) - 5'h01 && cpu_wait_q;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("wait not counted per processor clock");

  property p_other_free;
    @(posedge core_clk) disable iff (!rst_n)
      accept && !is_conv(cpu_req) && !is_serial(cpu_req) |=>
        periph_q.strobe && !cpu_wait_q ##1 cpu_done_q;
  endproperty
  a_other_free: assert property (p_other_free)
    else $error("unlisted register access was delayed");

  c_serial: cover property (@(posedge core_clk) disable iff (!rst_n)
    cpu_done_q && serial_q);
  c_conv_max: cover property (@(posedge core_clk) disable iff (!rst_n)
    cpu_done_q && conv_q && waited_q == {ratio_q, 1'b1});
  c_conv_min: cover property (@(posedge core_clk) disable iff (!rst_n)
    cpu_done_q && conv_q && ratio_q == 4'hC && waited_q == 5'h02);

endmodule

// ---- test/pbwb_periph_model.sv ----
`timescale 1ns/1ps

// Peripheral register file behind the bridge
module pbwb_periph_model (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // Bridge side
  input  wire pbwb_pkg::pbwb_periph_type periph,
  output logic [7:0]                    rdata
);
  import pbwb_pkg::*;

  logic [7:0] regs_q [8];

  // Reset pattern, then capture writes on strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= 8'h5A ^ 8'(i * 17);
      end
    end else if (periph.strobe && periph.write) begin
      regs_q[periph.target] <= periph.wdata;
    end
  end

  // Data valid only in the strobe cycle, inverted outside it
  assign rdata = periph.strobe ? regs_q[periph.target] : ~regs_q[periph.target];
endmodule

// ---- test/tb_peripheral_bus_wait_bridge.sv ----
`timescale 1ns/1ps

module tb_peripheral_bus_wait_bridge;
  import pbwb_pkg::*;

  // ************
  // Signals
  // ************
  logic            core_clk;
  logic            rst_n;
  pbwb_req_type    cpu_req;
  logic            cpu_wait_q;
  logic            cpu_done_q;
  logic [7:0]      cpu_rdata_q;
  pbwb_div_type    div_sel;
  logic            periph_clk_run;
  pbwb_periph_type periph_q;
  logic [7:0]      periph_rdata;
  logic [7:0]      shadow [8];
  int              miscompares;
  int              n_checks;
  int              ph;
  int              ratio;
  int              wmin;
  int              wmax;
  int              ratios [6] = '{2, 3, 4, 6, 8, 12};

  pbwb_bridge pbwb_bridge_i (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .cpu_req        (cpu_req),
    .cpu_wait_q     (cpu_wait_q),
    .cpu_done_q     (cpu_done_q),
    .cpu_rdata_q    (cpu_rdata_q),
    .div_sel        (div_sel),
    .periph_clk_run (periph_clk_run),
    .periph_q       (periph_q),
    .periph_rdata   (periph_rdata)
  );

  pbwb_periph_model pbwb_periph_model_i (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .periph   (periph_q),
    .rdata    (periph_rdata)
  );

  // Clock
  always #4 core_clk = ~core_clk;

  // Converter clock phase, frozen while the peripheral clock stops
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 0;
    end else if (periph_clk_run) begin
      ph <= (ph >= ratio - 1) ? 0 : ph + 1;
    end
  end

  // Expected wait clocks for one access
  function automatic int exp_wait(input logic wr, input pbwb_target_type t, input int p);
    int conv;
    conv = (p == ratio - 1) ? ((ratio <= 4) ? 1 : 2) : 2 * ratio + 1 - 2 * p;
    case (t)
      PBWB_SERIAL_A_RECEIVE_STATUS, PBWB_SERIAL_B_RECEIVE_STATUS: return wr ? 0 : 1;
      PBWB_CONVERTER_MODE_REG, PBWB_CONVERTER_CHANNEL_SELECT,
      PBWB_CONVERTER_PORT_CONFIG: return wr ? conv : 0;
      PBWB_CONVERTER_RESULT_REG: return wr ? 0 : conv;
      default: return 0;
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input pbwb_div_type d);
    rst_n = 1'b0;
    div_sel = d;
    ratio = ratios[int'(d)];
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      shadow[i] = 8'h5A ^ 8'(i * 17);
    end
  endtask

  // One access, entered and left at a falling edge
  task automatic access(input logic wr, input pbwb_target_type t, input logic [7:0] wd);
    int w;
    int n;
    int bad;
    int stb;
    w = exp_wait(wr, t, ph);
    n = 0;
    bad = 0;
    stb = 0;
    cpu_req = '{valid: 1'b1, write: wr, target: t, wdata: wd};
    @(negedge core_clk);
    cpu_req.valid = 1'b0;
    forever begin
      n++;
      if ((cpu_wait_q === 1'b1) != (n <= w)) bad++;
      if (periph_q.strobe === 1'b1) begin
        stb = n;
        check({4'h0, periph_q.write, periph_q.target}, {4'h0, wr, t});
        if (wr) check(periph_q.wdata, wd);
      end
      if (cpu_done_q === 1'b1 || n > 40) break;
      @(negedge core_clk);
    end
    if (w > 1 || (w == 1 && t >= PBWB_CONVERTER_MODE_REG)) begin
      wmin = (w < wmin) ? w : wmin;
      wmax = (w > wmax) ? w : wmax;
    end
    check(8'(bad), 8'h00);
    check(8'(n), 8'(w + 2));
    check(8'(stb), 8'(w + 1));
    if (wr) begin
      shadow[t] = wd;
    end else begin
      check(cpu_rdata_q, shadow[t]);
    end
    @(negedge core_clk);
    check({7'h00, cpu_done_q}, 8'h00);
  endtask

  // Every target in both directions
  task automatic t_all_targets();
    do_reset(PBWB_DIV2);
    for (int k = 0; k < 14; k++) begin
      access(!k[0], pbwb_target_type'(k / 2), 8'(k * 29));
    end
  endtask

  // Every converter clock ratio, every starting phase
  task automatic t_ratio_sweep();
    for (int d = 0; d < 6; d++) begin
      do_reset(pbwb_div_type'(d));
      wmin = 99;
      wmax = 0;
      for (int p = 0; p < ratio; p++) begin
        for (int k = 0; k < 4; k++) begin
          while (ph != p) @(negedge core_clk);
          access(k != 3, pbwb_target_type'(k + 3), 8'(p * 7 + k));
        end
      end
      check(8'(wmax), 8'(2 * ratio + 1));
      check(8'(wmin), (ratio <= 4) ? 8'h01 : 8'h02);
    end
  endtask

  // Stopped peripheral clock: only wait-free accesses meanwhile
  task automatic t_clock_stopped();
    do_reset(PBWB_DIV8);
    repeat (3) @(negedge core_clk);
    periph_clk_run = 1'b0;
    access(1'b1, PBWB_OTHER, 8'hC3);
    repeat (5) @(negedge core_clk);
    periph_clk_run = 1'b1;
    access(1'b0, PBWB_CONVERTER_RESULT_REG, 8'h00);
    access(1'b0, PBWB_SERIAL_B_RECEIVE_STATUS, 8'h00);
  endtask

  // Watchdog
  initial begin
    #400000;
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    cpu_req = '0;
    div_sel = PBWB_DIV2;
    periph_clk_run = 1'b1;
    ratio = 2;
    miscompares = 0;
    n_checks = 0;
    @(negedge core_clk);
    t_all_targets();
    t_ratio_sweep();
    t_clock_stopped();
    end_of_test();
  end
endmodule
